/* File: src/pcd_decoder.sv */
// Purpose: decode program-counter operand specifiers and branch targets
// Assumes: caller presents stream bytes with valid/ready, one per cycle
// Notes: relative deferred modes read memory through a simple request port; absolute does not
`timescale 1ns/1ps
`include "pcd_defines.svh"
module pcd_decoder (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Program counter load (redirect)
    input wire logic pc_load,
    input wire logic [31:0] pc_load_value,
    // Request
    input wire logic req_valid,
    input wire pcd_pkg::pcd_req_t req_kind,
    input wire logic [7:0] req_byte,
    input wire pcd_pkg::pcd_size_t req_size,
    output logic req_ready,
    // Trailing byte stream
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic byte_ready,
    // Memory read for deferred modes
    output logic mem_req,
    output logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [31:0] mem_data,
    // Results
    output logic [31:0] pc_value,
    output logic res_valid,
    output logic res_is_addr,
    output logic [31:0] res_value,
    output logic res_unpredictable,
    output logic res_not_pc
);
    import pcd_pkg::*;

    // Controller states, one-hot
    typedef enum logic [3:0] {
        PCD_IDLE = 4'b0001,
        PCD_FETCH = 4'b0010,
        PCD_CALC = 4'b0100,
        PCD_MEM = 4'b1000
    } pcd_state_t;

    pcd_state_t state_ff, nxt_state;
    logic [31:0] pc_ff, nxt_pc;          // Program counter
    logic [3:0] mode_ff, nxt_mode;       // Latched mode field
    logic branch_ff, nxt_branch;         // Branch displacement in progress
    logic [1:0] cnt_ff, nxt_cnt;         // Bytes taken so far
    logic [1:0] last_ff, nxt_last;       // Field size minus one
    logic res_valid_ff, nxt_res_valid;
    logic res_addr_ff, nxt_res_addr;
    logic [31:0] res_ff, nxt_res;
    logic unp_ff, nxt_unp;
    logic notpc_ff, nxt_notpc;
    pcd_acc_if acc_bus ();

    // Specifier split into mode and register
    wire [3:0] spec_mode = req_byte[7:`PCD_MODE_LSB];
    wire [3:0] spec_reg = req_byte[3:0];
    wire names_pc = (spec_reg == `PCD_PC_REG);
    wire reg_or_idx = (spec_mode == `PCD_MODE_REG) || (spec_mode == `PCD_MODE_INDEX);
    wire deferred = (mode_ff == `PCD_MODE_ABS) || (mode_ff == `PCD_MODE_BRELD)
        || (mode_ff == `PCD_MODE_WRELD) || (mode_ff == `PCD_MODE_LRELD);
    wire take = (state_ff == PCD_FETCH) && byte_valid;
    wire field_done = take && (cnt_ff == last_ff);

    // Field size of a PC mode: byte, word or longword after the specifier
    function automatic logic [1:0] field_size(input logic [3:0] m, input logic [1:0] imm);
        logic [1:0] s;
        s = 2'h3;
        if (m == `PCD_MODE_IMM) begin
            s = imm;
        end else if (m == `PCD_MODE_BREL || m == `PCD_MODE_BRELD) begin
            s = 2'h0;
        end else if (m == `PCD_MODE_WREL || m == `PCD_MODE_WRELD) begin
            s = 2'h1;
        end
        return s;
    endfunction : field_size

    // Sign extension of a byte or word displacement to 32 bits
    function automatic logic [31:0] sext(input logic [31:0] v, input logic [1:0] sz);
        logic [31:0] r;
        r = v;
        if (sz == 2'h0) begin
            r = {{24{v[7]}}, v[7:0]};
        end else if (sz == 2'h1) begin
            r = {{16{v[15]}}, v[15:0]};
        end
        return r;
    endfunction : sext

    // Last field byte merged with the gathered bytes
    logic [31:0] merged;
    always_comb begin
        merged = acc_bus.value;
        merged[cnt_ff*8 +: 8] = byte_data;
    end

    // Relative sum uses the counter past the final byte; field_done adds it
    wire [31:0] pc_after = pc_ff + 32'h0000_0001;
    wire [31:0] rel_sum = pc_after + sext(merged, last_ff);

    assign acc_bus.clear = (state_ff == PCD_IDLE);
    assign acc_bus.load = take;
    assign acc_bus.byte_in = byte_data;
    assign acc_bus.index = cnt_ff;
    assign req_ready = (state_ff == PCD_IDLE);
    assign byte_ready = (state_ff == PCD_FETCH);
    assign mem_req = (state_ff == PCD_MEM);
    assign mem_addr = res_ff;

    // Controller: decode, gather trailing bytes, form result
    always_comb begin
        nxt_state = state_ff;
        nxt_pc = pc_ff;
        nxt_mode = mode_ff;
        nxt_branch = branch_ff;
        nxt_cnt = cnt_ff;
        nxt_last = last_ff;
        nxt_res_valid = 1'b0;
        nxt_res_addr = res_addr_ff;
        nxt_res = res_ff;
        nxt_unp = unp_ff;
        nxt_notpc = notpc_ff;
        unique case (state_ff)
            PCD_IDLE: begin
                if (req_valid) begin
                    nxt_pc = pc_ff + 32'h0000_0001;
                    nxt_cnt = 2'h0;
                    nxt_branch = (req_kind == PCD_REQ_BRANCH);
                    nxt_mode = spec_mode;
                    if (req_kind == PCD_REQ_BRANCH) begin
                        // Branch: req_size picks byte or word displacement
                        nxt_last = {1'b0, req_size[0]};
                        nxt_pc = pc_ff;                       // Opcode already counted
                        nxt_state = PCD_FETCH;
                    end else if (req_kind == PCD_REQ_SPEC) begin
                        nxt_notpc = !names_pc;
                        nxt_unp = names_pc && reg_or_idx;
                        if (names_pc && spec_mode[3]) begin
                            nxt_last = field_size(spec_mode, req_size);
                            nxt_state = PCD_FETCH;
                        end else begin
                            // Other modes belong to the general path; flag only
                            nxt_res_valid = 1'b1;
                            nxt_res_addr = 1'b0;
                            nxt_res = 32'h0000_0000;
                        end
                    end
                end
            end
            PCD_FETCH: begin
                if (take) begin
                    nxt_pc = pc_ff + 32'h0000_0001;
                    nxt_cnt = cnt_ff + 2'h1;
                    if (field_done) begin
                        nxt_state = PCD_CALC;
                    end
                end
                if (field_done) begin
                    if (branch_ff) begin
                        nxt_res = rel_sum;
                        nxt_res_addr = 1'b1;
                    end else if (mode_ff == `PCD_MODE_IMM) begin
                        nxt_res = merged;
                        nxt_res_addr = 1'b0;
                    end else if (mode_ff == `PCD_MODE_ABS) begin
                        nxt_res = merged;
                        nxt_res_addr = 1'b1;
                    end else begin
                        nxt_res = rel_sum;
                        nxt_res_addr = 1'b1;
                    end
                end
            end
            PCD_CALC: begin
                if (!branch_ff && deferred && mode_ff != `PCD_MODE_ABS) begin
                    nxt_state = PCD_MEM;
                end else begin
                    nxt_res_valid = 1'b1;
                    nxt_state = PCD_IDLE;
                end
            end
            PCD_MEM: begin
                if (mem_ack) begin
                    nxt_res = mem_data;
                    nxt_res_valid = 1'b1;
                    nxt_state = PCD_IDLE;
                end
            end
            default: begin
                nxt_state = PCD_IDLE;
            end
        endcase
        if (pc_load) begin
            nxt_pc = pc_load_value;
        end
    end

    // State registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= PCD_IDLE;
            pc_ff <= `PCD_PC_RESET;
            mode_ff <= 4'h0;
            branch_ff <= 1'b0;
            cnt_ff <= 2'h0;
            last_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            mode_ff <= nxt_mode;
            branch_ff <= nxt_branch;
            cnt_ff <= nxt_cnt;
            last_ff <= nxt_last;
        end
    end

    // Result registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_valid_ff <= 1'b0;
            res_addr_ff <= 1'b0;
            res_ff <= 32'h0000_0000;
            unp_ff <= 1'b0;
            notpc_ff <= 1'b0;
        end else begin
            res_valid_ff <= nxt_res_valid;
            res_addr_ff <= nxt_res_addr;
            res_ff <= nxt_res;
            unp_ff <= nxt_unp;
            notpc_ff <= nxt_notpc;
        end
    end

    // Byte accumulator
    pcd_accum u_accum (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .acc(acc_bus.acc)
    );

    assign pc_value = pc_ff;
    assign res_valid = res_valid_ff;
    assign res_is_addr = res_addr_ff;
    assign res_value = res_ff;
    assign res_unpredictable = unp_ff;
    assign res_not_pc = notpc_ff;
endmodule : pcd_decoder

/* File: src/pcd_defines.svh */
// Purpose: constants for the program-counter operand specifier decoder
// Assumes: byte-wide instruction stream, 32-bit addresses
// Notes: modes are the high nibble of a specifier byte
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH
`define PCD_PC_REG 4'hf
`define PCD_MODE_LSB 4
`define PCD_MODE_IMM 4'h8
`define PCD_MODE_ABS 4'h9
`define PCD_MODE_BREL 4'ha
`define PCD_MODE_BRELD 4'hb
`define PCD_MODE_WREL 4'hc
`define PCD_MODE_WRELD 4'hd
`define PCD_MODE_LREL 4'he
`define PCD_MODE_LRELD 4'hf
`define PCD_MODE_INDEX 4'h4
`define PCD_MODE_REG 4'h5
`define PCD_PC_RESET 32'h0000_0000
`endif

/* File: src/pcd_pkg.sv */
// Purpose: types shared by the decoder files
// Assumes: nothing beyond the defines header
// Notes: request kinds for the decoder front end
package pcd_pkg;
    // Kind of work the decoder is asked to do
    typedef enum logic [1:0] {
        PCD_REQ_OPCODE = 2'h0,
        PCD_REQ_SPEC = 2'h1,
        PCD_REQ_BRANCH = 2'h2
    } pcd_req_t;
    // Size of a trailing field in bytes minus one
    typedef logic [1:0] pcd_size_t;
endpackage : pcd_pkg

/* File: src/pcd_acc_if.sv */
// Purpose: carrier between decoder control and byte accumulator
// Assumes: one clock
// Notes: accumulator gathers little-endian bytes
`timescale 1ns/1ps
interface pcd_acc_if;
    logic clear;          // Start a new field
    logic load;           // Take one byte
    logic [7:0] byte_in;  // Byte to take
    logic [1:0] index;    // Byte position in field
    logic [31:0] value;   // Gathered field
    modport ctl (output clear, output load, output byte_in, output index, input value);
    modport acc (input clear, input load, input byte_in, input index, output value);
endinterface : pcd_acc_if

/* File: src/pcd_accum.sv */
// Purpose: gathers up to four stream bytes into a longword
// Assumes: bytes arrive least significant first
// Notes: value is a register
`timescale 1ns/1ps
module pcd_accum (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control side
    pcd_acc_if.acc acc
);
    logic [31:0] value_ff;
    logic [31:0] nxt_value;
    // Place the byte in its lane; clear drops older lanes
    always_comb begin
        nxt_value = acc.clear ? 32'h0000_0000 : value_ff;
        if (acc.load) begin
            nxt_value[acc.index*8 +: 8] = acc.byte_in;
        end
    end
    // Field register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            value_ff <= 32'h0000_0000;
        end else begin
            value_ff <= nxt_value;
        end
    end
    assign acc.value = value_ff;
endmodule : pcd_accum

/* File: testbench/pcd_decoder_assertions.sv */
// Purpose: concurrent checks on the decoder's top-level ports
// Assumes: one clock domain, rst_n asynchronous active low
// Notes: attached to every decoder instance by the bind at the foot
`timescale 1ns/1ps
`include "pcd_defines.svh"
module pcd_decoder_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Counter load, request and stream
    input wire logic pc_load,
    input wire logic [31:0] pc_load_value,
    input wire logic req_valid,
    input wire pcd_pkg::pcd_req_t req_kind,
    input wire logic [7:0] req_byte,
    input wire logic req_ready,
    input wire logic byte_valid,
    input wire logic byte_ready,
    // Memory and results
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [31:0] mem_data,
    input wire logic [31:0] pc_value,
    input wire logic res_valid,
    input wire logic res_is_addr,
    input wire logic [31:0] res_value,
    input wire logic res_unpredictable,
    input wire logic res_not_pc
);
    import pcd_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Qualified request and byte takes, with a redirect masking the advance
    wire logic take_req = req_valid && req_ready && !pc_load;
    wire logic take_spec = take_req && req_kind == PCD_REQ_SPEC;
    wire logic pc_named = req_byte[3:0] == `PCD_PC_REG;
    wire logic reg_or_idx = req_byte[7:4] == `PCD_MODE_REG || req_byte[7:4] == `PCD_MODE_INDEX;
    opcode_step_a: assert property (
        take_req && req_kind == PCD_REQ_OPCODE |=> pc_value == $past(pc_value) + 32'h1)
        else $error("opcode did not step counter");
    byte_step_a: assert property (
        byte_valid && byte_ready && !pc_load |=> pc_value == $past(pc_value) + 32'h1)
        else $error("stream byte did not step counter");
    branch_hold_a: assert property (
        take_req && req_kind == PCD_REQ_BRANCH |=> $stable(pc_value))
        else $error("branch request moved counter");
    pc_redirect_a: assert property (
        pc_load |=> pc_value == $past(pc_load_value))
        else $error("counter load not taken");
    unpred_flag_a: assert property (
        take_spec && pc_named && reg_or_idx |=> res_valid && res_unpredictable)
        else $error("unpredictable case not flagged");
    not_pc_a: assert property (
        take_spec && !pc_named |=> res_valid && res_not_pc)
        else $error("other register not flagged");
    defer_wait_a: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("deferred read dropped early");
    defer_result_a: assert property (
        mem_req && mem_ack |=> res_valid && res_is_addr && res_value == $past(mem_data))
        else $error("deferred longword not used");
    one_flight_a: assert property (
        byte_ready |-> !req_ready)
        else $error("request open while gathering");
    // A request taken in the strobe cycle may legally give the next result at once
    res_pulse_a: assert property (
        res_valid && !take_req |=> !res_valid)
        else $error("result strobe longer than one cycle");
endmodule : pcd_decoder_assertions

bind pcd_decoder pcd_decoder_assertions chk_u (.sys_clk, .rst_n, .pc_load, .pc_load_value,
    .req_valid, .req_kind, .req_byte, .req_ready, .byte_valid, .byte_ready, .mem_req,
    .mem_addr, .mem_ack, .mem_data, .pc_value, .res_valid, .res_is_addr, .res_value,
    .res_unpredictable, .res_not_pc);

/* File: testbench/testbench.sv */
// Purpose: self-checking bench for the counter-based operand decoder
// Assumes: inputs change at the falling edge, results sampled there too
// Notes: table rows cover each counter mode; reset and odd cases follow
`timescale 1ns/1ps
module testbench;
    import pcd_pkg::*;
    // One table row: request, trailing field and its byte count
    typedef struct {
        pcd_req_t kind;     // Request kind
        logic [7:0] spec;   // Specifier byte
        pcd_size_t size;    // Immediate size or branch width
        logic [31:0] field; // Trailing field, low byte first
        int n;              // Bytes in the field
    } pcd_row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pc_load = 1'b0;
    logic [31:0] pc_load_value = 32'h0;
    logic req_valid = 1'b0;
    pcd_req_t req_kind = PCD_REQ_OPCODE;
    logic [7:0] req_byte = 8'h00;
    pcd_size_t req_size = 2'h0;
    logic byte_valid = 1'b0;
    logic [7:0] byte_data = 8'h00;
    logic mem_ack = 1'b0;
    logic [31:0] mem_data = 32'h0;
    wire logic req_ready, byte_ready, mem_req, res_valid;
    wire logic res_is_addr, res_unpredictable, res_not_pc;
    wire logic [31:0] mem_addr, pc_value, res_value;
    int bad_count = 0;
    int samples_checked = 0;
    pcd_row_t rows [11];
    pcd_decoder dut_u (.sys_clk, .rst_n, .pc_load, .pc_load_value, .req_valid, .req_kind,
        .req_byte, .req_size, .req_ready, .byte_valid, .byte_data, .byte_ready, .mem_req,
        .mem_addr, .mem_ack, .mem_data, .pc_value, .res_valid, .res_is_addr, .res_value,
        .res_unpredictable, .res_not_pc);
    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;
    // Verdict and end of run
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk32(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk32
    task automatic chk1(string what, logic exp, logic got);
        chk32(what, {31'h0, exp}, {31'h0, got});
    endtask : chk1
    // A bound ran out: count it and close
    task automatic hang(string what);
        bad_count++;
        $display("MISMATCH %s expected 1 seen timeout", what);
        wrap_up();
    endtask : hang
    // Request held until taken at a rising edge with req_ready high
    task automatic send_req(pcd_req_t k, logic [7:0] b, pcd_size_t s);
        int i;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_kind = k;
        req_byte = b;
        req_size = s;
        for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge sys_clk);
        if (req_ready !== 1'b1) hang("req_ready");
        @(posedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
    endtask : send_req
    // One trailing byte, same hold discipline
    task automatic send_byte(logic [7:0] d);
        int i;
        @(negedge sys_clk);
        byte_valid = 1'b1;
        byte_data = d;
        for (i = 0; i < 20 && byte_ready !== 1'b1; i++) @(negedge sys_clk);
        if (byte_ready !== 1'b1) hang("byte_ready");
        @(posedge sys_clk);
        @(negedge sys_clk);
        byte_valid = 1'b0;
    endtask : send_byte
    task automatic get_res;
        int i;
        for (i = 0; i < 30 && res_valid !== 1'b1; i++) @(negedge sys_clk);
        if (res_valid !== 1'b1) hang("res_valid");
    endtask : get_res
    // Slow memory: stall two cycles before answering the deferred read
    task automatic ack_mem(logic [31:0] exp_addr, logic [31:0] d);
        int i;
        for (i = 0; i < 30 && mem_req !== 1'b1; i++) @(negedge sys_clk);
        if (mem_req !== 1'b1) hang("mem_req");
        repeat (2) @(negedge sys_clk);
        chk32("mem_addr", exp_addr, mem_addr);
        mem_ack = 1'b1;
        mem_data = d;
        @(posedge sys_clk);
        @(negedge sys_clk);
        mem_ack = 1'b0;
        mem_data = ~d;
    endtask : ack_mem
    // Sign extension of an n-byte field
    function automatic logic [31:0] sext(logic [31:0] f, int n);
        if (n == 1) return {{24{f[7]}}, f[7:0]};
        if (n == 2) return {{16{f[15]}}, f[15:0]};
        return f;
    endfunction : sext
    // Main sequence
    initial begin
        logic [31:0] exp_pc, sum, want;
        logic [3:0] mode;
        logic [7:0] odd [4];
        int k;
        rows = '{
            '{PCD_REQ_SPEC, 8'h8f, 2'h0, 32'h06, 1},
            '{PCD_REQ_SPEC, 8'h8f, 2'h3, 32'h1234_5678, 4},
            '{PCD_REQ_SPEC, 8'h9f, 2'h0, 32'h0067_4533, 4},
            '{PCD_REQ_SPEC, 8'haf, 2'h0, 32'h80, 1},
            '{PCD_REQ_SPEC, 8'hcf, 2'h0, 32'h1000, 2},
            '{PCD_REQ_SPEC, 8'hef, 2'h0, 32'hffff_fff0, 4},
            '{PCD_REQ_SPEC, 8'hbf, 2'h0, 32'h4d, 1},
            '{PCD_REQ_SPEC, 8'hdf, 2'h0, 32'h8000, 2},
            '{PCD_REQ_SPEC, 8'hff, 2'h0, 32'h100, 4},
            '{PCD_REQ_BRANCH, 8'h00, 2'h0, 32'hfe, 1},
            '{PCD_REQ_BRANCH, 8'h00, 2'h1, 32'hff00, 2}};
        odd = '{8'h5f, 8'h4f, 8'h85, 8'h6f};
        repeat (10) @(negedge sys_clk);
        chk32("pc_value", 32'h0, pc_value);
        chk1("req_ready", 1'b1, req_ready);
        chk1("byte_ready", 1'b0, byte_ready);
        rst_n = 1'b1;
        // Redirect, then an opcode byte
        @(negedge sys_clk);
        pc_load = 1'b1;
        pc_load_value = 32'h0000_2000;
        @(negedge sys_clk);
        pc_load = 1'b0;
        chk32("pc_value", 32'h0000_2000, pc_value);
        send_req(PCD_REQ_OPCODE, 8'h00, 2'h0);
        exp_pc = 32'h0000_2001;
        chk32("pc_value", exp_pc, pc_value);
        // Table of counter modes and branch displacements
        foreach (rows[r]) begin
            send_req(rows[r].kind, rows[r].spec, rows[r].size);
            mode = rows[r].spec[7:4];
            if (rows[r].kind == PCD_REQ_SPEC) exp_pc = exp_pc + 32'h1;
            for (k = 0; k < rows[r].n; k++) send_byte(rows[r].field[8*k +: 8]);
            exp_pc = exp_pc + 32'(rows[r].n);
            sum = exp_pc + sext(rows[r].field, rows[r].n);
            want = (mode >= 4'ha || rows[r].kind == PCD_REQ_BRANCH) ? sum : rows[r].field;
            if (rows[r].kind == PCD_REQ_SPEC && mode[0] && mode > 4'h9) begin
                want = 32'h6000_0000 + 32'(r);
                ack_mem(sum, want);
            end
            get_res();
            chk32("pc_value", exp_pc, pc_value);
            chk32("res_value", want, res_value);
            // Branch rows carry mode 0, so they expect an address as well
            chk1("res_is_addr", mode != 4'h8, res_is_addr);
        end
        // Register and index mode with the counter, another register, mode 6
        foreach (odd[j]) begin
            send_req(PCD_REQ_SPEC, odd[j], 2'h0);
            get_res();
            chk1("res_unpredictable", j < 2, res_unpredictable);
            chk1("res_not_pc", j == 2, res_not_pc);
        end
        // Reset in the middle of a word displacement
        send_req(PCD_REQ_SPEC, 8'hcf, 2'h0);
        send_byte(8'h12);
        rst_n = 1'b0;
        @(negedge sys_clk);
        chk32("pc_value", 32'h0, pc_value);
        chk1("byte_ready", 1'b0, byte_ready);
        chk1("req_ready", 1'b1, req_ready);
        rst_n = 1'b1;
        send_req(PCD_REQ_OPCODE, 8'h00, 2'h0);
        chk32("pc_value", 32'h1, pc_value);
        wrap_up();
    end
endmodule : testbench
